/* File: src/lin_break_sync_timer.sv */
// Purpose: LIN slave header timing: break timer and sync timer
// Assumes: Plain register port, data one cycle after read strobe
// Notes:   Timer clocks are tick enables divided from sys_clk
`timescale 1ns/1ps
module lin_break_sync_timer
  import lin_hs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              linRx,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  output logic                   syncIrq
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Full-word address compare, shared by every decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] base);
    hit = (a == base);
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  rx_edge_t           rxEdge;       // Qualified bus level and edges
  logic [CTL_W-1:0]   ctl;          // sync_control contents
  logic [7:0]         edgeCfg;      // sync_edge_config low byte
  logic [BRK_W-1:0]   brkCmp;       // break_timer_compare
  logic [BRK_W-1:0]   brkTimer;     // Running break count
  logic               brkRun;       // Break timer counting
  logic               cmpSeen;      // Compare reached this low pulse
  logic [SYNC_W-1:0]  syncTimer;    // sync_timer_value
  logic               syncRun;      // Sync timer counting
  logic [EDGE_W-1:0]  fallCount;    // Falling edges this frame
  logic [EDGE_W-1:0]  riseCount;    // Rising edges this frame
  logic [ST_W-1:0]    status;       // sync_status sticky bits
  frame_state_t       state;        // Frame tracking state
  frame_state_t       next_state;
  logic [DIV_W-1:0]   syncDiv;      // 5 MHz divider
  logic [DIV_W-1:0]   lpDiv;        // 131 kHz divider
  logic [DIV_W-1:0]   clrCnt;       // Self-clear delay counter
  logic               clrBusy;      // A self-clearing bit is set
  logic               syncTick;
  logic               lpTick;

  // ==========================================================
  // Receive pin conditioning
  // ==========================================================
  // Pin passes three stages so each edge is seen exactly once
  lin_rx_sync u_rx_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .rxPin   (linRx),
    .rxEdge  (rxEdge)
  );

  // ==========================================================
  // Decode
  // ==========================================================
  logic wrCtl, wrCfg, wrBrk, wrSta, rdBrk;
  logic logicRst;    // Whole sync logic held in reset
  logic edgeClr;     // Edge counters held clear
  logic enabled;     // Sync logic allowed to run
  logic linMode;     // LIN mode (not bit-serial)
  logic stopRise;    // Stop on rising edges
  logic [EDGE_W-1:0] startEdge;
  logic [EDGE_W-1:0] stopEdge;

  assign wrCtl     = regWr & hit(regAddr, SYNC_CONTROL_ADR);
  assign wrCfg     = regWr & hit(regAddr, EDGE_CFG_ADR);
  assign wrBrk     = regWr & hit(regAddr, BREAK_ADR);
  assign wrSta     = regWr & hit(regAddr, SYNC_STATUS_ADR);
  assign rdBrk     = regRd & hit(regAddr, BREAK_ADR);
  assign logicRst  = ctl[CTL_RESET];
  assign edgeClr   = ctl[CTL_EDGECLR];
  assign enabled   = ctl[CTL_ENABLE] & ~logicRst;
  assign linMode   = ~ctl[CTL_MODE];
  assign stopRise  = ctl[CTL_STOPRISE];
  assign startEdge = edgeCfg[START_LSB +: EDGE_W];
  assign stopEdge  = edgeCfg[STOP_LSB +: EDGE_W];

  // ==========================================================
  // Tick dividers
  // ==========================================================
  assign syncTick = (syncDiv == SYNC_LAST);
  assign lpTick   = (lpDiv == LP_LAST);

  // Free-running dividers; the ticks stand for the slow clocks
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      syncDiv <= '0;
      lpDiv   <= '0;
    end
    else
    begin
      syncDiv <= syncTick ? '0 : syncDiv + 12'h001;
      lpDiv   <= lpTick ? '0 : lpDiv + 12'h001;
    end
  end

  // ==========================================================
  // Registers written by software
  // ==========================================================
  logic clrDone;
  assign clrDone = clrBusy & (clrCnt == CLR_LAST);
  assign clrBusy = ctl[CTL_RESET] | ctl[CTL_EDGECLR];

  // Control: reset and edge-clear bits drop after 15 us
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctl    <= '0;
      clrCnt <= '0;
    end
    else if (wrCtl)
    begin
      ctl    <= regWdata[CTL_W-1:0];
      clrCnt <= '0;
    end
    else if (clrDone)
    begin
      ctl[CTL_RESET]   <= 1'b0;
      ctl[CTL_EDGECLR] <= 1'b0;
      clrCnt           <= '0;
    end
    else if (clrBusy)
    begin
      clrCnt <= clrCnt + 12'h001;
    end
  end

  // Edge config and compare; soft reset restores them as well
  always_ff @(posedge sys_clk)
  begin
    if (srst | logicRst)
    begin
      edgeCfg <= EDGE_CFG_RST;
      brkCmp  <= BRK_CMP_RST;
    end
    else
    begin
      if (wrCfg)
      begin
        edgeCfg <= regWdata[7:0];
      end
      if (wrBrk)
      begin
        brkCmp <= regWdata[BRK_W-1:0];
      end
    end
  end

  // ==========================================================
  // Break timer
  // ==========================================================
  logic brkEqual;    // Compare reached, first time this pulse
  logic brkOvf;      // Timer wraps past its top count
  assign brkEqual = brkRun & linMode & ~cmpSeen
                  & (brkTimer == brkCmp);
  assign brkOvf   = brkRun & lpTick & (brkTimer == BRK_MAX);

  // Timer is zeroed by any fall or by a read; the write path
  // never touches it, only the compare register above
  always_ff @(posedge sys_clk)
  begin
    if (srst | logicRst)
    begin
      brkTimer <= '0;
      brkRun   <= 1'b0;
      cmpSeen  <= 1'b0;
    end
    else
    begin
      if (rxEdge.fall | rdBrk)
      begin
        brkTimer <= '0;
      end
      else if (brkRun & lpTick)
      begin
        brkTimer <= brkTimer + 12'h001;
      end
      // Keeps counting past compare until the bus rises or the count wraps
      if (rxEdge.fall & enabled)
      begin
        brkRun <= 1'b1;
      end
      else if (rxEdge.rise | brkOvf | ~enabled)
      begin
        brkRun <= 1'b0;
      end
      if (rxEdge.fall)
      begin
        cmpSeen <= 1'b0;
      end
      else if (brkEqual)
      begin
        cmpSeen <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Edge counting
  // ==========================================================
  logic newFrame;               // Fall that may begin a break
  logic [EDGE_W-1:0] next_fallCount;
  logic [EDGE_W-1:0] next_riseCount;
  logic [EDGE_W-1:0] fallInc;
  logic [EDGE_W-1:0] riseInc;

  assign newFrame = rxEdge.fall & ((state == S_IDLE) | (state == S_DONE));
  assign fallInc  = (&fallCount) ? fallCount : fallCount + 4'h1;
  assign riseInc  = (&riseCount) ? riseCount : riseCount + 4'h1;

  // Falling edge opening the break is counted as number one
  always_comb
  begin
    next_fallCount = fallCount;
    next_riseCount = riseCount;
    if (newFrame)
    begin
      next_fallCount = 4'h1;
      next_riseCount = '0;
    end
    else if (rxEdge.fall)
    begin
      next_fallCount = fallInc;
    end
    else if (rxEdge.rise)
    begin
      next_riseCount = riseInc;
    end
  end

  // Counters only move while enabled; edge-clear holds them
  always_ff @(posedge sys_clk)
  begin
    if (srst | logicRst | edgeClr)
    begin
      fallCount <= '0;
      riseCount <= '0;
    end
    else if (enabled)
    begin
      fallCount <= next_fallCount;
      riseCount <= next_riseCount;
    end
  end

  // ==========================================================
  // Frame tracking
  // ==========================================================
  logic startHit;    // Start edge reached in the sync field
  logic stopHit;     // Stop edge reached while timing
  logic stopFall;
  logic stopRiseHit;

  assign startHit    = (state == S_SYNC) & rxEdge.fall & ~syncRun
                     & (next_fallCount == startEdge);
  assign stopFall    = rxEdge.fall & (next_fallCount == stopEdge);
  assign stopRiseHit = rxEdge.rise & (next_riseCount == stopEdge);
  assign stopHit     = (state == S_SYNC) & (syncRun | startHit)
                     & (stopRise ? stopRiseHit : stopFall);

  // Sync field is entered only after the compare was reached
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (rxEdge.fall)
        begin
          next_state = S_BREAK;
        end
      end
      S_BREAK:
      begin
        if (brkOvf)
        begin
          next_state = S_IDLE;
        end
        else if (rxEdge.rise)
        begin
          next_state = cmpSeen ? S_SYNC : S_IDLE;
        end
      end
      S_SYNC:
      begin
        if (stopHit)
        begin
          next_state = S_DONE;
        end
      end
      S_DONE:
      begin
        if (rxEdge.fall)
        begin
          next_state = S_BREAK;
        end
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
  end

  // State register; a disabled block waits in idle
  always_ff @(posedge sys_clk)
  begin
    if (srst | logicRst | ~enabled)
    begin
      state <= S_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Sync timer
  // ==========================================================
  // Counts 5 MHz ticks from start edge; holds the count at stop
  always_ff @(posedge sys_clk)
  begin
    if (srst | logicRst)
    begin
      syncTimer <= '0;
      syncRun   <= 1'b0;
    end
    else if (stopHit | ~enabled)
    begin
      syncRun <= 1'b0;
    end
    else if (startHit)
    begin
      syncTimer <= '0;
      syncRun   <= 1'b1;
    end
    else if (syncRun & syncTick & (syncTimer != SYNC_MAX))
    begin
      syncTimer <= syncTimer + 16'h0001;
    end
  end

  // ==========================================================
  // Status (write one to clear; a new event wins)
  // ==========================================================
  logic [ST_W-1:0] setMask;
  logic [ST_W-1:0] clrMask;

  assign setMask = {1'b0, brkOvf, 1'b0, stopHit, startHit, brkEqual};
  assign clrMask = wrSta ? regWdata[ST_W-1:0] : '0;

  // Sticky flags, so one bus event raises one request
  always_ff @(posedge sys_clk)
  begin
    if (srst | logicRst)
    begin
      status <= '0;
    end
    else
    begin
      status <= (status & ~clrMask) | setMask;
    end
  end

  // ==========================================================
  // Shared request line and read port
  // ==========================================================
  logic irqAny;
  logic [DATA_W-1:0] rdMux;

  assign irqAny = status[ST_BREAK] | status[ST_BRKERR]
                | (status[ST_START] & ctl[CTL_STARTIE])
                | (status[ST_STOP] & ctl[CTL_STOPIE]);

  // Unmapped addresses read as zero
  always_comb
  begin
    rdMux = '0;
    if (hit(regAddr, SYNC_CONTROL_ADR))
    begin
      rdMux[CTL_W-1:0] = ctl;
    end
    else if (hit(regAddr, SYNC_VALUE_ADR))
    begin
      rdMux[SYNC_W-1:0] = syncTimer;
    end
    else if (hit(regAddr, EDGE_CFG_ADR))
    begin
      rdMux[7:0] = edgeCfg;
    end
    else if (hit(regAddr, BREAK_ADR))
    begin
      rdMux[BRK_W-1:0] = brkTimer;
    end
    else if (hit(regAddr, SYNC_STATUS_ADR))
    begin
      rdMux[ST_W-1:0] = status;
      rdMux[ST_RSTOK] = ~logicRst;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      regRdata <= '0;
      syncIrq  <= 1'b0;
    end
    else
    begin
      regRdata <= regRd ? rdMux : '0;
      syncIrq  <= irqAny;
    end
  end

endmodule

/* File: src/lin_hs_pkg.sv */
// Purpose: Shared constants and types for the LIN break and sync timer
// Assumes: One 200 MHz system clock; 32-bit plain register port
// Notes:   Slow timer rates are made as tick enables from sys_clk
package lin_hs_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam int          ADDR_W           = 32;
  localparam int          DATA_W           = 32;
  localparam logic [31:0] SYNC_CONTROL_ADR = 32'hFFFF_0780;
  localparam logic [31:0] SYNC_VALUE_ADR   = 32'hFFFF_0788;
  localparam logic [31:0] EDGE_CFG_ADR     = 32'hFFFF_078C;
  localparam logic [31:0] BREAK_ADR        = 32'hFFFF_0790;
  localparam logic [31:0] SYNC_STATUS_ADR  = 32'hFFFF_0794;

  // ==========================================================
  // Field layouts and reset values
  // ==========================================================
  localparam int         EDGE_W       = 4;
  localparam int         START_LSB    = 0;
  localparam int         STOP_LSB     = 4;
  localparam logic [7:0] EDGE_CFG_RST = 8'h32;
  localparam int         BRK_W        = 12;
  localparam logic [11:0] BRK_CMP_RST = 12'h047;
  localparam logic [11:0] BRK_MAX     = 12'hFFF;
  localparam int          SYNC_W      = 16;
  localparam logic [15:0] SYNC_MAX    = 16'hFFFF;

  // Control bit positions
  localparam int CTL_W       = 8;
  localparam int CTL_RESET   = 0;
  localparam int CTL_EDGECLR = 1;
  localparam int CTL_ENABLE  = 2;
  localparam int CTL_STARTIE = 3;
  localparam int CTL_STOPIE  = 4;
  localparam int CTL_MODE    = 6;
  localparam int CTL_STOPRISE = 7;

  // Status bit positions
  localparam int ST_W      = 6;
  localparam int ST_BREAK  = 0;
  localparam int ST_START  = 1;
  localparam int ST_STOP   = 2;
  localparam int ST_BRKERR = 4;
  localparam int ST_RSTOK  = 5;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_HZ     = 200_000_000;
  localparam int CLK_PS     = 5000;
  localparam int SYNC_HZ    = 5_000_000;
  localparam int LP_HZ      = 131_000;
  localparam int SELFCLR_NS = 15_000;
  localparam int SYNC_DIV   = CLK_HZ / SYNC_HZ;
  localparam int LP_DIV     = CLK_HZ / LP_HZ;
  localparam int SELFCLR_CYC = (SELFCLR_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DIV_W      = 12;
  localparam logic [11:0] SYNC_LAST = 12'(SYNC_DIV - 1);
  localparam logic [11:0] LP_LAST   = 12'(LP_DIV - 1);
  localparam logic [11:0] CLR_LAST  = 12'(SELFCLR_CYC - 1);

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic level;
    logic fall;
    logic rise;
  } rx_edge_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_BREAK = 2'b01,
    S_SYNC  = 2'b10,
    S_DONE  = 2'b11
  } frame_state_t;

endpackage

/* File: src/lin_rx_sync.sv */
// Purpose: Bring the LIN receive pin into sys_clk and mark its edges
// Assumes: Pin is asynchronous; bus idles high
// Notes:   Level changes only when the second and third stages agree
`timescale 1ns/1ps
module lin_rx_sync
  import lin_hs_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     srst,
  input  wire logic     rxPin,
  output rx_edge_t      rxEdge
);

  // ==========================================================
  // Three-stage capture
  // ==========================================================
  logic     meta;      // First stage, read only by stageB
  logic     stageB;    // Second stage
  logic     stageC;    // Third stage
  logic     agreed;    // Stages two and three agree
  rx_edge_t next_rxEdge;

  assign agreed = (stageB == stageC);

  // Qualified level and one-cycle edge marks
  always_comb
  begin
    next_rxEdge.level = agreed ? stageC : rxEdge.level;
    next_rxEdge.fall  = agreed & rxEdge.level & ~stageC;
    next_rxEdge.rise  = agreed & ~rxEdge.level & stageC;
  end

  // Shift chain; reset to the recessive (high) level
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta   <= 1'b1;
      stageB <= 1'b1;
      stageC <= 1'b1;
      rxEdge <= '{level: 1'b1, fall: 1'b0, rise: 1'b0};
    end
    else
    begin
      meta   <= rxPin;
      stageB <= meta;
      stageC <= stageB;
      rxEdge <= next_rxEdge;
    end
  end

endmodule

/* File: verif/lin_break_sync_timer_props.sv */
// Purpose: Port-level checks for the LIN break and sync timer
// Assumes: One clock, srst synchronous and active high
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module lin_break_sync_timer_props
  import lin_hs_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire logic              linRx,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic              syncIrq
);
  // ==========================================================
  // Helpers
  // ==========================================================
  logic [7:0] sinceLow; // Cycles since the pin was last low
  wire        mapped = (regAddr == SYNC_CONTROL_ADR) || (regAddr == SYNC_VALUE_ADR) ||
                       (regAddr == EDGE_CFG_ADR) || (regAddr == BREAK_ADR) || (regAddr == SYNC_STATUS_ADR);

  // Saturates so a long idle bus never wraps back into range
  always_ff @(posedge sys_clk)
  begin
    if (srst || !linRx)
      sinceLow <= 8'h00;
    else if (sinceLow != 8'hFF)
      sinceLow <= sinceLow + 8'h01;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence brkRead;
    regRd && regAddr == BREAK_ADR;
  endsequence
  sequence stClear;
    regWr && regAddr == SYNC_STATUS_ADR && regWdata[5:0] == 6'h3F;
  endsequence

  // ==========================================================
  // Properties
  // ==========================================================
  a_rdata_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its slot");
  a_value_ro_width: assert property ($past(regRd && regAddr == SYNC_VALUE_ADR) |-> regRdata[31:16] == 16'h0)
    else $error("sync value wider than 16 bits");
  a_cfg_reserved_zero: assert property ($past(regRd && regAddr == EDGE_CFG_ADR) |-> regRdata[31:8] == 24'h0)
    else $error("edge config reserved bits not zero");
  a_brk_width: assert property ($past(regRd && regAddr == BREAK_ADR) |-> regRdata[31:12] == 20'h0)
    else $error("break timer wider than 12 bits");
  a_unmapped_zero: assert property ($past(regRd && !mapped) |-> regRdata == 32'h0)
    else $error("unmapped read not zero");
  a_brk_read_clears: assert property (brkRead ##1 brkRead |-> ##1 regRdata[11:0] <= 12'h001)
    else $error("break read did not clear timer");
  a_irq_needs_low: assert property ($rose(syncIrq) |-> sinceLow < 8'h20)
    else $error("interrupt without bus activity");
  a_irq_w1c_clear: assert property (linRx [*8] ##0 stClear |-> ##[1:2] !syncIrq)
    else $error("status clear did not drop interrupt");
  a_irq_sticky: assert property ($fell(syncIrq) |-> $past(regWr, 2) || $past(regWr, 3))
    else $error("interrupt dropped without a write");
endmodule

bind lin_break_sync_timer lin_break_sync_timer_props i_props (.sys_clk(sys_clk), .srst(srst), .linRx(linRx),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .syncIrq(syncIrq));

/* File: verif/lin_master_model.sv */
// Purpose: LIN master driving a break and a 0x55 sync byte
// Assumes: Bus idles high through its pull-up
// Notes:   Bit and break lengths are in sys_clk cycles
`timescale 1ns/1ps
module lin_master_model
  import lin_hs_pkg::*;
(
  input  wire logic sys_clk,
  output logic      linRx
);
  // Released bus sits at the pull-up level
  initial linRx = 1'b1;

  task automatic hold(input logic lvl, input int n);
    linRx <= lvl;
    repeat (n) @(posedge sys_clk);
  endtask

  // Break, delimiter, then start bit, 0x55 LSB first, stop bit
  task automatic send_frame(input int brk, input int bitc);
    logic [9:0] ch;
    ch = 10'b1_01010101_0;
    @(posedge sys_clk);
    hold(1'b0, brk);
    hold(1'b1, bitc);
    for (int i = 0; i < 10; i++)
      hold(ch[i], bitc);
    hold(1'b1, 2 * bitc);
  endtask
endmodule

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the LIN break and sync timer
// Assumes: 200 MHz sys_clk, plain register port
// Notes:   Sync counts get a small tolerance for tick phase
`timescale 1ns/1ps
module testbench;
  import lin_hs_pkg::*;
  logic              sys_clk, srst, linRx, regWr, regRd, syncIrq;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, rd;
  logic [7:0]        cfg;
  int                err_total, n_tests, seed, bitc;

  lin_master_model i_master (.sys_clk(sys_clk), .linRx(linRx));
  lin_break_sync_timer i_dut (.sys_clk(sys_clk), .srst(srst), .linRx(linRx), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .syncIrq(syncIrq));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Bus tasks and compares
  // ==========================================================
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_near(input logic [31:0] got, input int exp, input int tol);
    logic ok;
    n_tests++;
    ok = (got >= 32'((exp > tol) ? exp - tol : 0)) && (got <= 32'(exp + tol));
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, 32'(exp));
    end
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    reg_rd(a, rd);
    check_eq(rd, exp);
  endtask

  // Model: start at falling edge #start, stop at edge #stop of chosen type
  function automatic int exp_sync(input logic [7:0] c, input logic rising, input int b);
    int t0, t1;
    t0 = 2 * (int'(c[3:0]) - 2) * b;
    t1 = rising ? (1 + 2 * (int'(c[7:4]) - 2)) * b : 2 * (int'(c[7:4]) - 2) * b;
    return (t1 - t0) / SYNC_DIV;
  endfunction

  // Reads during the break; the compare rewrite must not touch the timer
  task automatic probe_break();
    repeat (3 * LP_DIV + 100) @(posedge sys_clk);
    reg_rd(BREAK_ADR, rd);
    check_near(rd, 3, 1);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= BREAK_ADR;
    @(posedge sys_clk);
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    check_near(regRdata, 0, 1);
    reg_wr(BREAK_ADR, 32'h3);
    repeat (2 * LP_DIV) @(posedge sys_clk);
    reg_rd(BREAK_ADR, rd);
    check_near(rd, 2, 1);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    seed = 83;
    err_total = 0;
    n_tests = 0;
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 32'h0;
    regWdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values and read-only places
    rd_chk(SYNC_VALUE_ADR, 32'h0);
    rd_chk(EDGE_CFG_ADR, 32'h32);
    rd_chk(BREAK_ADR, 32'h0);
    rd_chk(SYNC_STATUS_ADR, 32'h20);
    rd_chk(32'hFFFF_0784, 32'h0);
    cfg = 8'($random(seed));
    reg_wr(EDGE_CFG_ADR, {24'h0, cfg});
    rd_chk(EDGE_CFG_ADR, {24'h0, cfg});
    reg_wr(SYNC_VALUE_ADR, 32'($random(seed)));
    rd_chk(SYNC_VALUE_ADR, 32'h0);
    reg_wr(BREAK_ADR, 32'h3);
    $display("test registers done");
    // Falling stop, later stop edge, then rising stop
    for (int k = 0; k < 3; k++)
    begin
      cfg = (k == 1) ? 8'h62 : 8'h32;
      bitc = 300 + int'($unsigned($random(seed)) % 200);
      reg_wr(EDGE_CFG_ADR, {24'h0, cfg});
      reg_wr(SYNC_CONTROL_ADR, (k == 2) ? 32'h94 : 32'h14);
      reg_wr(SYNC_STATUS_ADR, 32'h3F);
      fork
        i_master.send_frame(((k == 0) ? 11 : 6) * LP_DIV, bitc);
        if (k == 0) probe_break();
      join
      rd_chk(SYNC_STATUS_ADR, 32'h27);
      check_eq({31'h0, syncIrq}, 32'h1);
      reg_rd(SYNC_VALUE_ADR, rd);
      check_near(rd, exp_sync(cfg, k == 2, bitc), 2);
    end
    $display("test frames done");
    // Break shorter than the compare value: no sync timing
    reg_wr(SYNC_STATUS_ADR, 32'h3F);
    i_master.send_frame(LP_DIV, 400);
    rd_chk(SYNC_STATUS_ADR, 32'h20);
    check_eq({31'h0, syncIrq}, 32'h0);
    // Disabled block ignores a full frame
    reg_wr(SYNC_CONTROL_ADR, 32'h0);
    i_master.send_frame(6 * LP_DIV, 400);
    rd_chk(SYNC_STATUS_ADR, 32'h20);
    $display("test refusals done");
    // Software reset restores defaults and self-clears
    reg_wr(EDGE_CFG_ADR, 32'h62);
    reg_wr(SYNC_CONTROL_ADR, 32'h1);
    rd_chk(SYNC_STATUS_ADR, 32'h0);
    rd = 32'h0;
    for (int i = 0; i < 2000 && rd[5] !== 1'b1; i++)
      reg_rd(SYNC_STATUS_ADR, rd);
    // A self-clear that never finishes counts as a mismatch
    if (rd[5] !== 1'b1)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, rd, 32'h20);
    end
    else
    begin
      rd_chk(EDGE_CFG_ADR, 32'h32);
      rd_chk(SYNC_CONTROL_ADR, 32'h0);
    end
    $display("test soft reset done");
    print_verdict();
  end
endmodule
